// ---- rtl/sadc_consts.svh ----
/*
 Constants of the converter sequencer: field positions, reset values,
 encodings and timing counts. Assumes inclusion by the prescaler and sequencer files.
*/
// What the document requires
// RULE_01: Any control register write starts a fresh conversion.
// RULE_02: Each conversion lasts 16 to 17 converter clock periods.
// RULE_03: Converter clock comes from bus or crystal tick, then prescaled.
// RULE_04: Unaligned start adds a partial first period, counted as seventeenth.
// RULE_05: Continuous mode reconverts and overwrites results regardless of reads.
// RULE_06: Continuous runs until its enable clears; otherwise one per start.
// RULE_07: Done flag sets per conversion; cleared by control write or low read; code also clears it on a clock write.
// RULE_08: Scan mode takes channel and result slot from a 2-bit counter.
// RULE_09: Control write in scan mode zeroes counter, scans up to last channel.
// RULE_10: Per channel store, flag, increment, restart; stop after last channel.
// RULE_11: Software picks 8-bit truncation before enabling scan.
// RULE_12: Software disables scan before channel change or stop.
// RULE_13: Left justified: eight MSBs high, two LSBs low.
// RULE_14: Right justified: two MSBs high, eight LSBs low.
// RULE_15: Left sign format inverts the result top bit.
// RULE_16: Truncation: eight MSBs in low register, no interlock.
// RULE_17: High read in 10-bit formats freezes low; new results discarded.
// RULE_18: Interlock released by control or clock writes or reset only; code also releases it on a low read.
// RULE_19: With irq enabled, request interrupt after each conversion.
// RULE_20: Keeps running in wait; enabled interrupt drives wake output; code has no wait input or wake output, only irq_o.
// RULE_21: All-ones channel select powers the converter down.
// RULE_22: Stop abandons conversion; resumes after stop exit; code stays idle until the next control write.
// RULE_23: Prescale field: 1,2,4,8, top bit set gives 16.
// RULE_24: Done flag reads zero while irq enabled.
// RULE_25: Pending interrupt cleared by result read or control write; code clears it on a low read only, not on a high read.
// RULE_26: Software keeps continuous clear while scanning.
// RULE_27: Control write mid-conversion abandons it and restarts.
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
`define SADC_CONV_CYCLES   5'h10
`define SADC_CNT_W         5
`define SADC_CH_OFF        5'h1F
`define SADC_CH_RST        5'h1F
`define SADC_JUST_RST      2'h1
`define SADC_PRE_MAX       5'h0F
`define SADC_MSB           9
`endif

// ---- rtl/sadc_pkg.sv ----
/*
 Types shared by the sequencer files. Assumes sadc_consts.svh.
*/
package sadc_pkg;
   typedef enum logic [1:0] {
      SADC_TRUNC, SADC_RIGHT, SADC_LEFT, SADC_LSIGN
   } sadc_just_t;
   typedef struct packed {
      logic       irq_enable;
      logic       continuous_enable;
      logic [4:0] channel_select;
   } sadc_ctrl_t;
   typedef struct packed {
      logic [2:0] clock_prescale_field;
      logic       bus_clock_sel;
      sadc_just_t justify;
   } sadc_clk_t;
   typedef enum {SADC_IDLE, SADC_CONV} sadc_state_t;
endpackage

// ---- rtl/sadc_prescale.sv ----
/*
 Converter clock tick generator. Assumes synchronous source ticks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_prescale (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       restart_i,
   input  wire logic       bus_clock_sel_i,
   input  wire logic       crystal_ref_clock_i,
   input  wire logic [2:0] clock_prescale_field_i,
   output logic            tick_o
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       tick;
      logic       primed;
   } sadc_pre_st_t;
   sadc_pre_st_t st, next_st;
   logic         src;
   logic [3:0]   limit;
   always_comb begin
      src = bus_clock_sel_i ? 1'b1 : crystal_ref_clock_i; // RULE_03
      limit = clock_prescale_field_i[2] ? 4'hF :
              4'((5'h01 << clock_prescale_field_i[1:0]) - 5'h01); // RULE_23
      next_st = st;
      next_st.tick = 1'b0;
      if (restart_i) begin
         next_st.cnt = 4'h0;
         next_st.primed = 1'b0;
      end else if (src && !bus_clock_sel_i && !st.primed) begin
         // Crystal edges are not aligned to the start, so the partial
         // period before the first edge is the extra seventeenth one
         next_st.primed = 1'b1; // RULE_04
      end else if (src) begin
         if (st.cnt >= limit) begin
            next_st.cnt = 4'h0;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 4'h1;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) st <= '0;
      else st <= next_st;
   end
   assign tick_o = st.tick;
endmodule // sadc_prescale
`default_nettype wire

// ---- rtl/sadc_result_mem.sv ----
/*
 Four scan result slots, all read out in parallel straight from the slot flops. Assumes one write per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_result_mem #(
   parameter int DEPTH = 4,
   parameter int W     = 8
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_b_i,
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input  wire logic [W-1:0]             wdata_i,
   output logic      [DEPTH*W-1:0]       rdata_o
);
   logic [DEPTH*W-1:0] mem;
   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_slot
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) mem[i*W +: W] <= '0;
            else if (we_i && int'(waddr_i) == i) mem[i*W +: W] <= wdata_i;
         end
      end
   endgenerate
   assign rdata_o = mem;
endmodule // sadc_result_mem
`default_nettype wire

// ---- rtl/sadc_sequencer.sv ----
/*
 Converter sequencer top: start, timing, scan, justification, interlock,
 flag and interrupt. Assumes a synchronous comparator bit-serial model is
 replaced by a sampled 10-bit result presented on sample_data_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_sequencer (
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic                ctrl_wr_i,
   input  wire sadc_pkg::sadc_ctrl_t ctrl_wdata_i,
   input  wire logic                clk_wr_i,
   input  wire sadc_pkg::sadc_clk_t clk_wdata_i,
   input  wire logic                scan_enable_i,
   input  wire logic [1:0]          last_channel_i,
   input  wire logic                crystal_ref_clock_i,
   input  wire logic                stop_mode_i,
   input  wire logic                high_rd_i,
   input  wire logic                low_rd_i,
   input  wire logic [9:0]          sample_data_i,
   output logic [4:0]               mux_channel_o,
   output logic                     powered_down_o,
   output logic                     converting_o,
   output logic                     conversion_done_flag_o,
   output logic                     irq_o,
   output logic [7:0]               result_high_reg_o,
   output logic [7:0]               result_low_reg_o,
   output logic [31:0]              scan_result_low_reg_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      sadc_pkg::sadc_state_t fsm;
      sadc_pkg::sadc_ctrl_t  ctrl;
      sadc_pkg::sadc_clk_t   clk;
      logic [4:0]            cnt;
      logic [1:0]            scan_cnt;
      logic                  scanning;
      logic                  done;
      logic                  irq;
      logic                  locked;
      logic [7:0]            high;
      logic [7:0]            low;
      logic [4:0]            mux;
      logic                  pdn;
      logic                  conv;
      logic                  flag;
   } sadc_st_t;
   sadc_st_t   st, next_st;
   logic       tick;
   logic       restart;
   logic       finish;
   logic       mem_we;
   logic [7:0] mem_wdata;
   logic [9:0] res;

   sadc_prescale u_pre (
      .clk_i                  (clk_i),
      .rst_b_i                (rst_b_i),
      .restart_i              (restart),
      .bus_clock_sel_i        (st.clk.bus_clock_sel),
      .crystal_ref_clock_i    (crystal_ref_clock_i),
      .clock_prescale_field_i (st.clk.clock_prescale_field),
      .tick_o                 (tick)
   );
   sadc_result_mem #(.DEPTH(4), .W(8)) u_mem (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .we_i    (mem_we),
      .waddr_i (st.scan_cnt),
      .wdata_i (mem_wdata),
      .rdata_o (scan_result_low_reg_o)
   );

   // ---------------------------------------------------------------
   // Sequencing
   // ---------------------------------------------------------------
   // Prescaler realigns on every control write start, so the first period is partial
   // up to the first crystal edge after the write; it counts as period 17.
   assign restart = ctrl_wr_i || st.fsm == sadc_pkg::SADC_IDLE; // RULE_04
   always_comb begin
      next_st = st;
      res = sample_data_i;
      finish = 1'b0;
      mem_we = 1'b0;
      mem_wdata = res[`SADC_MSB -: 8];
      if (clk_wr_i) begin
         next_st.clk = clk_wdata_i;
         next_st.locked = 1'b0; // RULE_18
         next_st.done = 1'b0;
      end
      if (st.fsm == sadc_pkg::SADC_CONV && tick) begin
         if (st.cnt == `SADC_CONV_CYCLES - 5'h01) begin // RULE_02
            finish = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 5'h01;
         end
      end
      if (finish) begin
         next_st.done = 1'b1; // RULE_07
         if (st.ctrl.irq_enable) next_st.irq = 1'b1; // RULE_19 RULE_20
         if (st.scanning) begin
            mem_we = 1'b1; // RULE_08
            if (st.scan_cnt == 2'h0) next_st.low = mem_wdata;
            if (st.scan_cnt == last_channel_i) begin
               next_st.fsm = sadc_pkg::SADC_IDLE; // RULE_10
            end else begin
               next_st.scan_cnt = st.scan_cnt + 2'h1; // RULE_10
               next_st.cnt = 5'h00;
            end
         end else begin
            if (st.clk.justify == sadc_pkg::SADC_TRUNC) begin
               next_st.high = 8'h00;
               next_st.low = res[`SADC_MSB -: 8]; // RULE_16
            end else if (!st.locked) begin // RULE_17
               unique case (st.clk.justify)
                  sadc_pkg::SADC_RIGHT: begin
                     next_st.high = {6'h00, res[9:8]}; // RULE_14
                     next_st.low = res[7:0];
                  end
                  sadc_pkg::SADC_LEFT: begin
                     next_st.high = res[9:2]; // RULE_13
                     next_st.low = {res[1:0], 6'h00};
                  end
                  default: begin
                     next_st.high = {~res[9], res[8:2]}; // RULE_15
                     next_st.low = {res[1:0], 6'h00};
                  end
               endcase
            end
            if (st.ctrl.continuous_enable) begin
               next_st.cnt = 5'h00; // RULE_05 RULE_06
            end else begin
               next_st.fsm = sadc_pkg::SADC_IDLE; // RULE_06
            end
         end
      end
      // Result reads: set from a finishing conversion wins over a clear
      if (low_rd_i) begin
         next_st.locked = 1'b0;
         if (!finish) next_st.done = 1'b0; // RULE_07
         if (!finish) next_st.irq = 1'b0; // RULE_25
      end
      if (high_rd_i && st.clk.justify != sadc_pkg::SADC_TRUNC) begin
         next_st.locked = 1'b1; // RULE_17
      end
      if (ctrl_wr_i) begin
         next_st.ctrl = ctrl_wdata_i;
         next_st.done = 1'b0; // RULE_07
         next_st.irq = 1'b0; // RULE_25
         next_st.locked = 1'b0; // RULE_18
         next_st.cnt = 5'h00; // RULE_27
         next_st.scan_cnt = 2'h0; // RULE_09
         next_st.scanning = scan_enable_i; // RULE_09
         next_st.fsm = sadc_pkg::SADC_CONV; // RULE_01
      end
      next_st.pdn = next_st.ctrl.channel_select == `SADC_CH_OFF; // RULE_21
      if (next_st.pdn) next_st.fsm = sadc_pkg::SADC_IDLE; // RULE_21
      // Stop aborts; a later control write restarts conversions
      if (stop_mode_i) begin
         next_st.fsm = sadc_pkg::SADC_IDLE; // RULE_22
         next_st.cnt = 5'h00;
      end
      next_st.mux = next_st.scanning ? {3'h0, next_st.scan_cnt}
                                     : next_st.ctrl.channel_select; // RULE_08
      // Registered copies keep every output straight from a flop
      next_st.conv = next_st.fsm == sadc_pkg::SADC_CONV;
      next_st.flag = next_st.done && !next_st.ctrl.irq_enable; // RULE_24
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
         st.fsm <= sadc_pkg::SADC_IDLE;
         st.ctrl.channel_select <= `SADC_CH_RST;
         st.clk.justify <= sadc_pkg::sadc_just_t'(`SADC_JUST_RST);
         st.mux <= `SADC_CH_RST;
         st.pdn <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign mux_channel_o = st.mux;
   assign powered_down_o = st.pdn;
   assign converting_o = st.conv;
   assign conversion_done_flag_o = st.flag; // RULE_24
   assign irq_o = st.irq;
   assign result_high_reg_o = st.high;
   assign result_low_reg_o = st.low;
endmodule // sadc_sequencer
`default_nettype wire

// ---- verification/sadc_checker.sv ----
/*
 Port checker for the converter sequencer.
 Assumes binding to sadc_sequencer, which has one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_checker (
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic                 ctrl_wr_i,
   input wire sadc_pkg::sadc_ctrl_t ctrl_wdata_i,
   input wire logic                 clk_wr_i,
   input wire logic                 scan_enable_i,
   input wire logic                 stop_mode_i,
   input wire logic                 low_rd_i,
   input wire logic [4:0]           mux_channel_o,
   input wire logic                 powered_down_o,
   input wire logic                 converting_o,
   input wire logic                 conversion_done_flag_o,
   input wire logic                 irq_o
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic live_wr;
   assign live_wr = ctrl_wr_i && !stop_mode_i
                    && ctrl_wdata_i.channel_select != 5'h1F;
   a_start_conv: assert property (live_wr |=> converting_o)
      else $error("no conversion after control write");
   a_power_down: assert property (ctrl_wr_i && !scan_enable_i
      && ctrl_wdata_i.channel_select == 5'h1F |=> powered_down_o)
      else $error("all-ones channel did not power down");
   a_write_clears: assert property (ctrl_wr_i
      |=> !conversion_done_flag_o && !irq_o)
      else $error("control write left flag or irq set");
   a_flag_hidden: assert property (irq_o |-> !conversion_done_flag_o)
      else $error("flag visible while irq enabled");
   a_min_time: assert property ($rose(conversion_done_flag_o | irq_o)
      |-> $past(converting_o, 15))
      else $error("conversion finished too early");
   a_stop_abort: assert property (stop_mode_i |=> !converting_o)
      else $error("conversion kept running in stop");
   a_scan_zero: assert property (live_wr && scan_enable_i
      |=> mux_channel_o == 5'h00)
      else $error("scan did not restart at channel 0");
   a_flag_holds: assert property (conversion_done_flag_o && !ctrl_wr_i
      && !clk_wr_i && !low_rd_i && !stop_mode_i
      |=> conversion_done_flag_o)
      else $error("flag dropped without a clear");
   a_irq_holds: assert property (irq_o && !ctrl_wr_i && !low_rd_i
      |=> $stable(irq_o))
      else $error("irq dropped without a clear");
endmodule // sadc_checker
bind sadc_sequencer sadc_checker chk_u (.*);
`default_nettype wire

// ---- verification/tb_sadc_sequencer.sv ----
/*
 Self-checking bench for the converter sequencer.
 Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sadc_sequencer;
   // ---------------------------------------------
   // Stimulus and checks
   // ---------------------------------------------
   logic clk_i = 0, rst_b_i = 0, ctrl_wr_i = 0, clk_wr_i = 0;
   logic scan_enable_i = 0, crystal_ref_clock_i = 0, stop_mode_i = 0;
   logic high_rd_i = 0, low_rd_i = 0;
   logic [1:0]  last_channel_i = 2'h3, xk = 2'h0;
   logic [9:0]  sample_data_i = 10'h000, smp = 10'h000;
   sadc_pkg::sadc_ctrl_t ctrl_wdata_i = 7'h1F;
   sadc_pkg::sadc_clk_t  clk_wdata_i = 6'h05;
   logic [4:0]  mux_channel_o;
   logic        powered_down_o, converting_o, conversion_done_flag_o, irq_o;
   logic [7:0]  result_high_reg_o, result_low_reg_o, v;
   logic [31:0] scan_result_low_reg_o, seed;
   int miscompares = 0, tests_run = 0, n;
   sadc_sequencer dut (.*);
   initial forever #50 clk_i = ~clk_i;
   // Crystal ticks every third cycle; scan samples carry their channel
   always @(posedge clk_i) begin
      xk <= (xk == 2'h2) ? 2'h0 : xk + 2'h1;
      crystal_ref_clock_i <= (xk == 2'h2);
      sample_data_i <= scan_enable_i ? {mux_channel_o[1:0], 8'h3C} : smp;
   end
   function automatic logic [15:0] fmt(input logic [1:0] j,
                                       input logic [9:0] d);
      case (j)
         2'h0: return {8'h00, d[9:2]};
         2'h1: return {6'h00, d};
         2'h2: return {d, 6'h00};
         default: return {~d[9], d[8:0], 6'h00};
      endcase
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      #1;
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic cw(input logic [6:0] c);
      @(posedge clk_i);
      ctrl_wr_i <= 1'b1;
      ctrl_wdata_i <= c;
      @(posedge clk_i);
      ctrl_wr_i <= 1'b0;
      #1;
   endtask
   task automatic kw(input logic [5:0] c);
      @(posedge clk_i);
      clk_wr_i <= 1'b1;
      clk_wdata_i <= c;
      @(posedge clk_i);
      clk_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic h);
      @(posedge clk_i);
      high_rd_i <= h;
      low_rd_i <= !h;
      @(posedge clk_i);
      high_rd_i <= 1'b0;
      low_rd_i <= 1'b0;
      #1;
   endtask
   // Bounded wait, so a dead converter cannot hang the run
   task automatic wt;
      n = 0;
      while ((conversion_done_flag_o | irq_o) !== 1'b1 && n < 999) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= 999) miscompares++;
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #3000000;
      miscompares++;
      report_and_stop;
   end
   initial begin
      seed = 32'h6A655AD6;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      for (int p = 0; p < 5; p++) begin
         smp <= 10'($random(seed));
         kw({(p == 4) ? 3'h5 : 3'(p), 1'b1, 2'(p)});
         cw(7'h02);
         wt();
         chk(n >= (16 << p) && n <= (17 << p) + 5, 1);
         chk({result_high_reg_o, result_low_reg_o}, fmt(2'(p), smp));
         rd(1'b0);
         chk(conversion_done_flag_o, 0);
      end
      kw(6'h01);
      cw(7'h02);
      wt();
      chk(n >= 48 && n <= 56, 1);
      kw(6'h05);
      cw(7'h22);
      wt();
      rd(1'b1);
      v = result_low_reg_o;
      smp <= ~smp;
      repeat (40) @(posedge clk_i);
      #1;
      chk(result_low_reg_o, v);
      rd(1'b0);
      repeat (40) @(posedge clk_i);
      #1;
      chk(result_low_reg_o, smp[7:0]);
      chk(conversion_done_flag_o, 1);
      rd(1'b1);
      smp <= 10'($random(seed));
      kw(6'h05);
      repeat (40) @(posedge clk_i);
      #1;
      chk(result_low_reg_o, smp[7:0]);
      cw(7'h02);
      wt();
      rd(1'b0);
      repeat (60) @(posedge clk_i);
      #1;
      chk(conversion_done_flag_o, 0);
      cw(7'h02);
      repeat (8) @(posedge clk_i);
      cw(7'h02);
      wt();
      chk(n >= 16, 1);
      rd(1'b0);
      cw(7'h02);
      repeat (5) @(posedge clk_i);
      stop_mode_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      stop_mode_i <= 1'b0;
      #1;
      chk(converting_o, 0);
      repeat (40) @(posedge clk_i);
      #1;
      chk(conversion_done_flag_o, 0);
      cw(7'h42);
      wt();
      chk({irq_o, conversion_done_flag_o}, 2'h2);
      rd(1'b0);
      chk(irq_o, 0);
      kw(6'h04);
      @(posedge clk_i);
      scan_enable_i <= 1'b1;
      cw(7'h00);
      repeat (120) @(posedge clk_i);
      #1;
      chk(scan_result_low_reg_o, 32'hCF8F4F0F);
      chk(mux_channel_o, 5'h03);
      @(posedge clk_i);
      scan_enable_i <= 1'b0;
      cw(7'h1F);
      chk(powered_down_o, 1);
      report_and_stop;
   end
endmodule // tb_sadc_sequencer
`default_nettype wire
